// ### hw/uco_baud.sv
`timescale 1ns/1ns
module uco_baud (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // rate control and tick
  uco_baud_if.gen bif
);

  logic [9:0] cnt;
  logic [9:0] lim;

  // sixteen ticks per bit: N+1 clocks fast, 4(N+1) slow
  always_comb
  begin
    lim = bif.high_speed ? {2'b00, bif.divisor} : {bif.divisor, 2'b11};
  end

  // free running prescaler, restarted while the port is off
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= 10'h000;
      bif.os_tick <= 1'b0;
    end
    else if (ce)
    begin
      if (bif.clear)
      begin
        cnt <= 10'h000;
        bif.os_tick <= 1'b0;
      end
      else if (cnt >= lim)
      begin
        cnt <= 10'h000;
        bif.os_tick <= 1'b1;
      end
      else
      begin
        cnt <= cnt + 10'h001;
        bif.os_tick <= 1'b0;
      end
    end
  end

endmodule

// ### hw/uco_baud_if.sv
`timescale 1ns/1ns
interface uco_baud_if;
  logic [7:0] divisor;
  logic high_speed;
  logic clear;
  logic os_tick;
  modport ctl (output divisor, output high_speed, output clear, input os_tick);
  modport gen (input divisor, input high_speed, input clear, output os_tick);
endinterface

// ### hw/uco_pkg.sv
package uco_pkg;

  // register byte addresses
  localparam int AXI_AW = 8;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_DIVISOR = 8'h0c;
  localparam logic [7:0] ADDR_DATA = 8'h10;

  // control one fields
  localparam int C1_PORT_ON = 7;
  localparam int C1_NINE = 6;
  localparam int C1_PAR_ON = 5;
  localparam int C1_ODD = 4;
  localparam int C1_TWO_STOP = 3;
  localparam int C1_BREAK = 2;
  localparam int C1_RX9 = 1;
  localparam int C1_TX9 = 0;
  // control two fields
  localparam int C2_TX_ON = 7;
  localparam int C2_RX_ON = 6;
  localparam int C2_HIGH = 5;
  localparam int C2_ADDR = 4;
  localparam int C2_WAKE = 3;
  localparam int C2_RIE = 2;
  localparam int C2_TX_IDLE_IRQ_ENABLE = 1;
  localparam int C2_TX_EMPTY_IRQ_ENABLE = 0;

  // reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] DIVISOR_RST = 8'h00;

  // bit timing: phases in oversample ticks, break and frame lengths in bits
  localparam logic [3:0] PH_LAST = 4'hf;
  localparam logic [3:0] PH_S0 = 4'h7;
  localparam logic [3:0] PH_S1 = 4'h8;
  localparam logic [3:0] PH_S2 = 4'h9;
  localparam logic [3:0] BREAK_BITS = 4'hd;
  localparam logic [3:0] FRAME_BASE = 4'ha;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01,
    TX_BREAK = 2'b10
  } uco_tx_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } uco_rx_t;

  // even parity of the data bits below the parity slot
  function automatic logic f_par(input logic [8:0] w, input logic nine);
    return nine ? ^w[7:0] : ^w[6:0];
  endfunction

  // majority of three samples
  function automatic logic f_maj(input logic [2:0] v);
    return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction

  // whole frame, start bit in bit 0, ones above the payload
  function automatic logic [11:0] f_frame(input logic [7:0] d, input logic d8,
                                          input logic nine, input logic par_on,
                                          input logic odd);
    logic [8:0] p;
    p = nine ? {d8, d} : {1'b1, d};
    if (par_on && nine)
      p[8] = f_par(p, 1'b1) ^ odd;
    else if (par_on)
      p[7] = f_par(p, 1'b0) ^ odd;
    return {2'b11, p, 1'b0};
  endfunction

  // word address lies inside the map
  function automatic logic f_known(input logic [7:0] a);
    return a == ADDR_STATUS || a == ADDR_CTRL1 || a == ADDR_CTRL2 ||
           a == ADDR_DIVISOR || a == ADDR_DATA;
  endfunction

endpackage

// ### hw/uco_uart_ctl.sv
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
module uco_uart_ctl (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // serial pins
  input wire logic rx_in,
  output logic tx_pin,
  output logic tx_pin_oe,
  output logic rx_pin_own,
  // power and interrupt request
  input wire logic power_down,
  output logic wake_req,
  output logic irq_req
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] divisor;
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane0;
  logic aw_got;
  logic w_got;
  uco_pkg::uco_tx_t tx_state;
  logic [7:0] tx_buf;
  logic tx_full;
  logic [11:0] tx_shift;
  logic [3:0] tx_left;
  logic [3:0] tx_ph;
  logic [3:0] tx_brk;
  uco_pkg::uco_rx_t rx_state;
  logic [3:0] rx_ph;
  logic [3:0] rx_cnt;
  logic [8:0] rx_sh;
  logic [2:0] rx_vote;
  logic rx_noisy;
  logic rx_prev;
  logic [7:0] rx_buf;
  logic rx_ninth;
  logic rx_ready;
  logic overrun;
  logic framing;
  logic par_err;
  logic noise;
  logic stat_seen;
  logic rx_ev;
  logic tx_idle_flag_prev;
  logic tempty_prev;

  wire serial_port_on = ctrl1[uco_pkg::C1_PORT_ON];
  wire nine = ctrl1[uco_pkg::C1_NINE];
  wire par_on = ctrl1[uco_pkg::C1_PAR_ON];
  wire par_odd = ctrl1[uco_pkg::C1_ODD];
  wire two_stop = ctrl1[uco_pkg::C1_TWO_STOP];
  wire send_break = ctrl1[uco_pkg::C1_BREAK];
  wire tx_ninth = ctrl1[uco_pkg::C1_TX9];
  wire transmitter_on = ctrl2[uco_pkg::C2_TX_ON];
  wire receiver_on = ctrl2[uco_pkg::C2_RX_ON];

  // transmit and receive sections held in reset when not owned
  wire tx_rst = !(serial_port_on && transmitter_on);
  wire rx_rst = !(serial_port_on && receiver_on);

  // derived status
  wire tx_buffer_empty = !tx_full;
  wire tx_idle_flag = !tx_full && tx_state == uco_pkg::TX_IDLE;
  wire rx_idle_flag = rx_state == uco_pkg::RX_IDLE;

  // bus strobes
  wire wr_go = aw_got && w_got && !bvalid;
  wire rd_go = arvalid && arready;
  wire wr_on = wr_go && wr_lane0;
  wire data_wr = wr_on && wr_addr == uco_pkg::ADDR_DATA;
  wire rd_stat = rd_go && araddr == uco_pkg::ADDR_STATUS;
  wire rd_data = rd_go && araddr == uco_pkg::ADDR_DATA;

  // receive sampling
  wire os_tick;
  wire rx_fall = rx_prev && !rx_in;
  wire rx_bit = uco_pkg::f_maj(rx_vote);
  // received word as it stands in the shifter once the stop bit is due
  wire [8:0] rx_word = nine ? rx_sh : {1'b0, rx_sh[8:1]};
  wire rx_addr_bit = nine ? rx_word[8] : rx_word[7];
  wire rx_par_bad = (nine ? rx_word[8] : rx_word[7]) !=
                    (uco_pkg::f_par(rx_word, nine) ^ par_odd);

  ////////////////////////////////////////////////////////////////////////////
  // baud generator

  uco_baud_if bif ();

  assign bif.divisor = divisor;
  assign bif.high_speed = ctrl2[uco_pkg::C2_HIGH];
  assign bif.clear = !serial_port_on;
  assign os_tick = bif.os_tick;

  uco_baud u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(aclk_en),
    .bif(bif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  // software writes, then the port-off side effects
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl1 <= uco_pkg::CTRL1_RST;
      ctrl2 <= uco_pkg::CTRL2_RST;
      divisor <= uco_pkg::DIVISOR_RST;
    end
    else if (aclk_en)
    begin
      if (wr_on && wr_addr == uco_pkg::ADDR_CTRL1)
        ctrl1 <= {wr_byte[7:2], ctrl1[uco_pkg::C1_RX9], wr_byte[0]};
      if (wr_on && wr_addr == uco_pkg::ADDR_CTRL2)
        ctrl2 <= wr_byte;
      if (wr_on && wr_addr == uco_pkg::ADDR_DIVISOR)
        divisor <= wr_byte;
      if (!serial_port_on)
      begin
        ctrl1[uco_pkg::C1_BREAK] <= 1'b0;
        ctrl2[uco_pkg::C2_TX_ON] <= 1'b0;
        ctrl2[uco_pkg::C2_RX_ON] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  // write address and data taken in either order, answered together
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wr_addr <= 8'h00;
      wr_byte <= 8'h00;
      wr_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= uco_pkg::RESP_OKAY;
    end
    else if (aclk_en)
    begin
      if (awvalid && awready)
      begin
        wr_addr <= awaddr;
        aw_got <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wr_byte <= wdata[7:0];
        wr_lane0 <= wstrb[0];
        w_got <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= uco_pkg::f_known(wr_addr) ? uco_pkg::RESP_OKAY : uco_pkg::RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // read answered one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= uco_pkg::RESP_OKAY;
    end
    else if (aclk_en)
    begin
      if (rd_go)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= uco_pkg::f_known(araddr) ? uco_pkg::RESP_OKAY : uco_pkg::RESP_SLVERR;
        unique case (araddr)
          uco_pkg::ADDR_STATUS:
            rdata <= {24'h000000, par_err, noise, framing, overrun,
                      rx_idle_flag, rx_ready, tx_idle_flag, tx_buffer_empty};
          uco_pkg::ADDR_CTRL1:
            rdata <= {24'h000000, ctrl1[7:2], rx_ninth, 1'b0};
          uco_pkg::ADDR_CTRL2:
            rdata <= {24'h000000, ctrl2};
          uco_pkg::ADDR_DIVISOR:
            rdata <= {24'h000000, divisor};
          uco_pkg::ADDR_DATA:
            rdata <= {24'h000000, rx_buf};
          default:
            rdata <= 32'h0000_0000;
        endcase
      end
      if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter

  // buffer, frame shifter and break generator
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state <= uco_pkg::TX_IDLE;
      tx_buf <= 8'h00;
      tx_full <= 1'b0;
      tx_shift <= 12'hfff;
      tx_left <= 4'h0;
      tx_ph <= 4'h0;
      tx_brk <= 4'h0;
    end
    else if (aclk_en)
    begin
      if (tx_rst)
      begin
        tx_state <= uco_pkg::TX_IDLE;
        tx_full <= 1'b0;
        tx_ph <= 4'h0;
      end
      else
      begin
        if (data_wr)
          tx_buf <= wr_byte;
        tx_full <= data_wr || (tx_full && tx_state != uco_pkg::TX_IDLE);
        unique case (tx_state)
          uco_pkg::TX_IDLE:
            if (tx_full)
            begin
              // lsb first, ninth bit from control one
              tx_shift <= uco_pkg::f_frame(tx_buf, tx_ninth, nine, par_on,
                                           par_odd);
              tx_left <= uco_pkg::FRAME_BASE + {3'b000, nine} + {3'b000, two_stop};
              tx_ph <= 4'h0;
              tx_state <= uco_pkg::TX_SHIFT;
            end
            else if (send_break)
            begin
              tx_brk <= 4'h0;
              tx_ph <= 4'h0;
              tx_state <= uco_pkg::TX_BREAK;
            end
          uco_pkg::TX_SHIFT:
            if (os_tick)
            begin
              tx_ph <= tx_ph + 4'h1;
              if (tx_ph == uco_pkg::PH_LAST)
              begin
                tx_shift <= {1'b1, tx_shift[11:1]};
                tx_left <= tx_left - 4'h1;
                if (tx_left == 4'h1)
                  tx_state <= uco_pkg::TX_IDLE;
              end
            end
          uco_pkg::TX_BREAK:
            if (tx_brk == uco_pkg::BREAK_BITS && !send_break)
              tx_state <= uco_pkg::TX_IDLE;
            else if (os_tick)
            begin
              tx_ph <= tx_ph + 4'h1;
              if (tx_ph == uco_pkg::PH_LAST && tx_brk != uco_pkg::BREAK_BITS)
                tx_brk <= tx_brk + 4'h1;
            end
          default:
            tx_state <= uco_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // pin drive and ownership
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_pin <= 1'b1;
      tx_pin_oe <= 1'b0;
      rx_pin_own <= 1'b0;
    end
    else if (aclk_en)
    begin
      tx_pin <= tx_rst || tx_state == uco_pkg::TX_IDLE ||
                (tx_state == uco_pkg::TX_SHIFT && tx_shift[0]);
      tx_pin_oe <= !tx_rst;
      rx_pin_own <= !rx_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver

  // line history for edge detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_prev <= 1'b1;
    else if (aclk_en)
      rx_prev <= rx_in;
  end

  // frame capture and receive flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_state <= uco_pkg::RX_IDLE;
      rx_ph <= 4'h0;
      rx_cnt <= 4'h0;
      rx_sh <= 9'h000;
      rx_vote <= 3'b111;
      rx_noisy <= 1'b0;
      rx_buf <= 8'h00;
      rx_ninth <= 1'b0;
      rx_ready <= 1'b0;
      overrun <= 1'b0;
      framing <= 1'b0;
      par_err <= 1'b0;
      noise <= 1'b0;
      stat_seen <= 1'b0;
      rx_ev <= 1'b0;
    end
    else if (aclk_en)
    begin
      rx_ev <= 1'b0;
      if (rx_rst)
      begin
        rx_state <= uco_pkg::RX_IDLE;
        rx_ready <= 1'b0;
        overrun <= 1'b0;
        framing <= 1'b0;
        par_err <= 1'b0;
        noise <= 1'b0;
        stat_seen <= 1'b0;
      end
      else
      begin
        // status read then data read clears the error flags; a data read alone clears rx_ready
        if (rd_stat)
          stat_seen <= 1'b1;
        if (rd_data)
        begin
          rx_ready <= 1'b0;
          stat_seen <= 1'b0;
          if (stat_seen)
          begin
            overrun <= 1'b0;
            framing <= 1'b0;
            par_err <= 1'b0;
            noise <= 1'b0;
          end
        end
        unique case (rx_state)
          uco_pkg::RX_IDLE:
            if (rx_fall)
            begin
              rx_ph <= 4'h0;
              rx_noisy <= 1'b0;
              rx_state <= uco_pkg::RX_START;
            end
          default:
            if (os_tick)
            begin
              rx_ph <= rx_ph + 4'h1;
              if (rx_ph == uco_pkg::PH_S0)
                rx_vote[0] <= rx_in;
              if (rx_ph == uco_pkg::PH_S1)
                rx_vote[1] <= rx_in;
              if (rx_ph == uco_pkg::PH_S2)
                rx_vote[2] <= rx_in;
              if (rx_ph == uco_pkg::PH_LAST)
              begin
                rx_noisy <= rx_noisy || !(&rx_vote) && (|rx_vote);
                if (rx_state == uco_pkg::RX_START)
                begin
                  rx_cnt <= 4'h0;
                  rx_state <= rx_bit ? uco_pkg::RX_IDLE : uco_pkg::RX_DATA;
                end
                else if (rx_state == uco_pkg::RX_DATA)
                begin
                  rx_sh <= {rx_bit, rx_sh[8:1]};
                  rx_cnt <= rx_cnt + 4'h1;
                  if (rx_cnt == (nine ? 4'h8 : 4'h7))
                    rx_state <= uco_pkg::RX_STOP;
                end
                else
                begin
                  rx_state <= uco_pkg::RX_IDLE;
                  if (ctrl2[uco_pkg::C2_ADDR] && !rx_addr_bit)
                    rx_ev <= 1'b0;
                  else if (rx_ready && !rd_data)
                  begin
                    overrun <= 1'b1;
                    rx_ev <= 1'b1;
                  end
                  else
                  begin
                    // low eight bits to the buffer, ninth only in nine-bit mode
                    rx_buf <= rx_word[7:0];
                    if (nine)
                      rx_ninth <= rx_word[8];
                    rx_ready <= 1'b1;
                    framing <= !rx_bit;
                    par_err <= par_on && rx_par_bad;
                    noise <= rx_noisy || !(&rx_vote) && (|rx_vote);
                    rx_ev <= 1'b1;
                  end
                end
              end
            end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request and wake-up

  // one-cycle request on each enabled flag setting
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_idle_flag_prev <= 1'b1;
      tempty_prev <= 1'b1;
      irq_req <= 1'b0;
      wake_req <= 1'b0;
    end
    else if (aclk_en)
    begin
      tx_idle_flag_prev <= tx_idle_flag;
      tempty_prev <= tx_buffer_empty;
      irq_req <= (ctrl2[uco_pkg::C2_RIE] && rx_ev) ||
                 (ctrl2[uco_pkg::C2_TX_IDLE_IRQ_ENABLE] && tx_idle_flag && !tx_idle_flag_prev) ||
                 (ctrl2[uco_pkg::C2_TX_EMPTY_IRQ_ENABLE] && tx_buffer_empty && !tempty_prev);
      wake_req <= ctrl2[uco_pkg::C2_WAKE] && power_down && rx_fall;
    end
  end

endmodule

// ### verif/uart_control_options_test.sv
`timescale 1ns/1ns
module uart_control_options_test;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, power_down;
  logic awready, wready, bvalid, arready, rvalid, rx_in, tx_pin, tx_pin_oe, rx_pin_own;
  logic wake_req, irq_req, t9, hs;
  logic [7:0] awaddr, araddr, d;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [11:0] got;
  logic [33:0] exp_q[$];
  int failures, checks_done, irq_cnt, wake_cnt, nb;

  uco_uart_ctl dut (.aclk, .aresetn, .aclk_en(1'b1), .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .rx_in, .tx_pin, .tx_pin_oe, .rx_pin_own, .power_down,
    .wake_req, .irq_req);
  uco_remote rem (.aclk, .tx_pin, .rx_line(rx_in));

  // clock
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // bus write, response noted for the monitor
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r);
    int n;
    @(posedge aclk);
    exp_q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && ++n < 200);
    bready <= 1'b0;
    if (n >= 200) begin failures++; end_of_test(); end
  endtask

  // bus read, data and response noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
    int n;
    @(posedge aclk);
    exp_q.push_back({r, 24'h0, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && ++n < 200);
    rready <= 1'b0;
    if (n >= 200) begin failures++; end_of_test(); end
  endtask

  // expected frame after the start bit; f = nine, parity, odd, two stop
  function automatic logic [11:0] frm(input logic [7:0] v, input logic b9,
                                      input logic [3:0] f);
    logic [8:0] p;
    int w;
    p = {b9, v};
    w = f[3] ? 8 : 7;
    if (f[2])
      p[w] = ^(p & ((9'h1 << w) - 9'h1)) ^ f[1];
    return f[3] ? {3'b111, p} : {4'hf, p[7:0]};
  endfunction

  // bus monitor takes the oldest note
  always @(posedge aclk)
    if ((bvalid && bready) || (rvalid && rready))
      chk(bvalid ? {bresp, 32'h0} : {rresp, rdata}, exp_q.pop_front());

  // request pulse counters
  always @(posedge aclk)
  begin
    irq_cnt += (irq_req === 1'b1);
    wake_cnt += (wake_req === 1'b1);
  end

  ////////////////////////////////////////////////////////////
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, power_down, aresetn} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    void'($urandom(32'h6c8f));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd(8'(i * 4), i == 0 ? 8'h0b : 8'h00, i == 5 ? 2'b10 : 2'b00);
    wr(8'h04, 8'h83, 2'b00);
    wr(8'h08, 8'hc0, 2'b00);
    rd(8'h04, 8'h80, 2'b00);
    rd(8'h00, 8'h0b, 2'b00);
    chk(34'({tx_pin_oe, rx_pin_own}), 34'h3);
    // every format at both speeds, idle and empty requests per frame
    for (int i = 0; i < 32; i++)
    begin
      d = 8'($urandom);
      t9 = 1'($urandom);
      hs = i[4];
      nb = 9 + i[3] + i[0];
      rem.bit_clks = hs ? 16 : 64;
      wr(8'h04, {1'b1, 4'(i), 2'b00, t9}, 2'b00);
      wr(8'h08, {2'b11, hs, 5'h03}, 2'b00);
      fork
        wr(8'h10, d, 2'b00);
        rem.grab(nb, got);
      join
      chk(34'(got), 34'(frm(d, t9, 4'(i)) & ((12'h1 << nb) - 12'h1)));
      repeat (64) @(posedge aclk);
    end
    chk(34'(irq_cnt), 34'd64);
    // address detect, wake while powered down
    wr(8'h04, 8'h80, 2'b00);
    wr(8'h08, 8'hfc, 2'b00);
    nb = irq_cnt;
    power_down <= 1'b1;
    rem.send(12'h100, 9);
    power_down <= 1'b0;
    repeat (8) @(posedge aclk); // idle gap so the receiver is back in idle
    rem.send(12'h1a5, 9);
    repeat (32) @(posedge aclk);
    rd(8'h00, 8'h0f, 2'b00);
    rd(8'h10, 8'ha5, 2'b00);
    chk(34'(irq_cnt - nb), 34'd1);
    chk(34'(wake_cnt), 34'd1);
    // break, then port off in mid-break
    wr(8'h04, 8'h84, 2'b00);
    @(posedge aclk); // pin lags the break state by one clock
    nb = 0;
    repeat (240) begin @(posedge aclk); nb += (tx_pin !== 1'b0); end
    chk(34'(nb), 34'd0);
    wr(8'h04, 8'h00, 2'b00);
    repeat (4) @(posedge aclk);
    chk(34'({tx_pin_oe, rx_pin_own, tx_pin}), 34'h1);
    rd(8'h08, 8'h3c, 2'b00);
    rd(8'h04, 8'h00, 2'b00);
    rd(8'h00, 8'h0b, 2'b00);
    end_of_test();
  end
endmodule

// ### verif/uco_remote.sv
`timescale 1ns/1ns
module uco_remote (
  // clock
  input wire logic aclk,
  // serial lines
  input wire logic tx_pin,
  output logic rx_line
);
  int bit_clks = 16;

  // line idles high between frames
  initial rx_line = 1'b1;

  // wait for a start bit, then sample mid-bit, first bit in bit 0
  task automatic grab(input int nb, output logic [11:0] v);
    int n;
    v = '0;
    n = 0;
    while (tx_pin !== 1'b0 && n < 5000)
    begin
      @(posedge aclk);
      n++;
    end
    if (n >= 5000) return; // no start bit: v stays zero, so the stop bits mismatch
    repeat (bit_clks / 2) @(posedge aclk);
    for (int i = 0; i < nb; i++)
    begin
      repeat (bit_clks) @(posedge aclk);
      v[i] = tx_pin;
    end
  endtask

  // start bit, then nb bits lowest first
  task automatic send(input logic [11:0] v, input int nb);
    rx_line <= 1'b0;
    repeat (bit_clks) @(posedge aclk);
    for (int i = 0; i < nb; i++)
    begin
      rx_line <= v[i];
      repeat (bit_clks) @(posedge aclk);
    end
    rx_line <= 1'b1;
  endtask
endmodule

// ### verif/uco_uart_ctl_chk.sv
`timescale 1ns/1ns
module uco_uart_ctl_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // serial and power
  input wire logic rx_in,
  input wire logic tx_pin,
  input wire logic tx_pin_oe,
  input wire logic power_down,
  input wire logic wake_req,
  input wire logic irq_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // bus answers and holds
  a_b_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer missing");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_r_answer: assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h0)
    else $error("read answer wrong");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  a_w_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while busy");
  a_r_refuse: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
  // pins and wake
  a_tx_free: assert property (!tx_pin_oe [*3] |-> tx_pin)
    else $error("unowned tx not idle");
  a_wake_cause: assert property (wake_req |-> $past(power_down) && !$past(rx_in))
    else $error("wake without cause");
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake too long");

  // main scenarios
  cover property (wake_req);
  cover property (irq_req);
  cover property ($fell(tx_pin));
endmodule

bind uco_uart_ctl uco_uart_ctl_chk chk (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
  .rx_in, .tx_pin, .tx_pin_oe, .power_down, .wake_req, .irq_req);
